// ---- hw/pin_bank_cfg.svh ----
/*
 Register offsets, field positions and reset values for the pin 5..8 setup bank.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef PIN_BANK_CFG_SVH
`define PIN_BANK_CFG_SVH
`define PINS_5_6_SETUP_IDX 8'h20
`define PINS_7_8_SETUP_IDX 8'h21
`define PINS_5_6_SETUP_ADDR 12'h080
`define PINS_7_8_SETUP_ADDR 12'h084
`define SETUP_RESET 8'h00
`define HI_LEVEL_BIT 7
`define HI_DIR_BIT 5
`define HI_REGCTL_BIT 4
`define LO_LEVEL_BIT 3
`define LO_DIR_BIT 1
`define LO_REGCTL_BIT 0
`define PIN_COUNT 4
`endif

// ---- hw/pin_bank_pkg.sv ----
/*
 Types for the pin 5..8 setup bank.
 Assumes the constants header is on the include path.
*/
`include "pin_bank_cfg.svh"
package pin_bank_pkg;
  typedef enum logic [1:0] {
    mode_function = 2'h0,
    mode_reg_out = 2'h1,
    mode_tristate = 2'h2,
    mode_reg_in = 2'h3
  } pin_mode_e;
  typedef struct packed {
    logic out_level;
    logic direction;
    logic register_control;
  } pin_setup_s;
  typedef struct packed {
    logic [`PIN_COUNT-1:0] out;
    logic [`PIN_COUNT-1:0] oe_n;
  } pad_drive_s;
endpackage

// ---- hw/pin_bank.sv ----
/*
 APB slave with two 8-bit setup registers steering pads of pins 5..8.
 Assumes an APB master on pclk and a pad ring that resolves out/oe_n and
 returns pad levels asynchronously.
*/
`timescale 1ns/1ns
`include "pin_bank_cfg.svh"
module pin_bank
  import pin_bank_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] func_out,
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe_n,
  output logic [3:0] pin_in_level
);
  logic [7:0] pins_5_6_setup_q;
  logic [7:0] pins_7_8_setup_q;
  logic [7:0] pins_5_6_setup_d;
  logic [7:0] pins_7_8_setup_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] in_level_q;
  logic [3:0] in_level_d;
  pad_drive_s drive_q;
  pad_drive_s drive_d;
  pin_setup_s setup [`PIN_COUNT];

  // One wait state: pready rises the cycle after the access phase starts
  wire access = psel && penable && !pready_q;
  // Writes land only at the edge where the master sees pready high
  wire done = psel && penable && pready_q;
  wire hit_56 = paddr == `PINS_5_6_SETUP_ADDR;
  wire hit_78 = paddr == `PINS_7_8_SETUP_ADDR;
  wire mapped = hit_56 || hit_78;
  wire wr_ok = done && pwrite && mapped && pstrb[0];
  wire wr_56 = wr_ok && hit_56;
  wire wr_78 = wr_ok && hit_78;

  // Reserved bits 6 and 2 are plain storage and reach no pad logic
  assign pins_5_6_setup_d = wr_56 ? pwdata[7:0] : pins_5_6_setup_q;
  assign pins_7_8_setup_d = wr_78 ? pwdata[7:0] : pins_7_8_setup_q;
  assign prdata_d = !access || pwrite ? 32'h0 :
                    hit_56 ? {24'h0, pins_5_6_setup_q} :
                    hit_78 ? {24'h0, pins_7_8_setup_q} : 32'h0;
  // Unmapped addresses are flagged; writes without the low lane are dropped quietly
  assign pslverr_d = access && !mapped;

  // Field mapping: pins 5 and 7 low nibble, 6 and 8 high nibble
  assign setup[0] = '{pins_5_6_setup_q[`LO_LEVEL_BIT], pins_5_6_setup_q[`LO_DIR_BIT],
                      pins_5_6_setup_q[`LO_REGCTL_BIT]};
  assign setup[1] = '{pins_5_6_setup_q[`HI_LEVEL_BIT], pins_5_6_setup_q[`HI_DIR_BIT],
                      pins_5_6_setup_q[`HI_REGCTL_BIT]};
  assign setup[2] = '{pins_7_8_setup_q[`LO_LEVEL_BIT], pins_7_8_setup_q[`LO_DIR_BIT],
                      pins_7_8_setup_q[`LO_REGCTL_BIT]};
  assign setup[3] = '{pins_7_8_setup_q[`HI_LEVEL_BIT], pins_7_8_setup_q[`HI_DIR_BIT],
                      pins_7_8_setup_q[`HI_REGCTL_BIT]};

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
      pin_mode_e mode;
      assign mode = pin_mode_e'({setup[i].direction, setup[i].register_control});
      // Remote control does not exist here, so register output needs no extra gate
      assign drive_d.out[i] = mode == mode_function ? func_out[i] :
                              mode == mode_reg_out ? setup[i].out_level : 1'b0;
      assign drive_d.oe_n[i] = !(mode == mode_function || mode == mode_reg_out);
      // Input level only follows the pad in register input mode
      assign in_level_d[i] = mode == mode_reg_in ? sync2_q[i] : in_level_q[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_5_6_setup_q <= `SETUP_RESET;
      pins_7_8_setup_q <= `SETUP_RESET;
    end else begin
      pins_5_6_setup_q <= pins_5_6_setup_d;
      pins_7_8_setup_q <= pins_7_8_setup_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= access;
      pslverr_q <= pslverr_d;
    end
  end

  // Pad levels are asynchronous; two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      in_level_q <= 4'h0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      in_level_q <= in_level_d;
    end
  end

  // Registered pad drive costs one cycle of latency but keeps pads glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= '{out: 4'h0, oe_n: 4'h0};
    end else begin
      drive_q <= drive_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad_out = drive_q.out;
  assign pad_oe_n = drive_q.oe_n;
  assign pin_in_level = in_level_q;
endmodule

// ---- tb/pin_bank_properties.sv ----
/* Port checker for pin_bank, bound to every instance.
   Assumes paddr stays put through each APB access. */
`timescale 1ns/1ns
`include "pin_bank_cfg.svh"
module pin_bank_properties (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb, func_out, pad_in, pad_out, pad_oe_n, pin_in_level
);
  logic [7:0] r56_q, r78_q;
  wire hit56 = paddr == `PINS_5_6_SETUP_ADDR;
  wire hit78 = paddr == `PINS_7_8_SETUP_ADDR;
  wire wr = psel && penable && pready && pwrite && pstrb[0];
  // Shadow copy, so pad checks need no view of the register bodies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {r56_q, r78_q} <= '0;
    else if (wr && hit56) r56_q <= pwdata[7:0];
    else if (wr && hit78) r78_q <= pwdata[7:0];
  end
  wire [3:0] lv = {r78_q[7], r78_q[3], r56_q[7], r56_q[3]};
  wire [3:0] dr = {r78_q[5], r78_q[1], r56_q[5], r56_q[1]};
  wire [3:0] en = {r78_q[4], r78_q[0], r56_q[4], r56_q[0]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  a_err_map: assert property (pready |-> pslverr == !(hit56 || hit78))
    else $error("error flag wrong for address");
  a_read_back: assert property (pready && !pwrite && !pslverr |->
    prdata == {24'h0, hit78 ? r78_q : r56_q}) else $error("read data wrong");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not idle");
  a_oe_by_dir: assert property ($past(presetn) |-> pad_oe_n == $past(dr))
    else $error("pad enable wrong");
  a_func_path: assert property ($past(presetn) |->
    (pad_out & $past(~dr & ~en)) == $past(func_out & ~dr & ~en)) else $error("func drive");
  a_level_drive: assert property ($past(presetn) |->
    (pad_out & $past(en & ~dr)) == $past(lv & en & ~dr)) else $error("level drive");
  a_tri_quiet: assert property ((pad_out & pad_oe_n) == 4'h0)
    else $error("released pad still driven");
endmodule
bind pin_bank pin_bank_properties chk (.*);

// ---- tb/pad_far_side.sv ----
/* Board side of pins 5..8.
   Assumes the bench sets the board level of released pads. */
`timescale 1ns/1ns
module pad_far_side (
  input wire logic [3:0] pad_out, pad_oe_n, board_level,
  output logic [3:0] pad_in
);
  // Released pads show the board, never a stale device value
  assign pad_in = (pad_out & ~pad_oe_n) | (board_level & pad_oe_n);
endmodule

// ---- tb/pin_bank_bench.sv ----
/* Self-checking bench for pin_bank.
   Assumes pad_far_side stands for the board. */
`timescale 1ns/1ns
`include "pin_bank_cfg.svh"
module pin_bank_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0, func_out = '0, lvl = '0, pad_in, pad_out, pad_oe_n, pin_in_level;
  int num_errors = 0, n_tests = 0, cyc = 0;
  // Row: select, data, func_out, pad_out, pad_oe_n
  logic [23:0] rows [6] = '{24'h000ff0, 24'h019a90, 24'h1b251c, 24'h06f00f, 24'h14ccc3,
    24'h000330};
  pin_bank uut (.*);
  pad_far_side far (.pad_out, .pad_oe_n, .board_level(lvl), .pad_in);
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 1000) begin
    num_errors++;
    summarize();
  end
  task automatic chk(input string n, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // psel stays up so a following call is a back-to-back setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {3'h0, s};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    er = pslverr;
    penable <= 1'h0;
  endtask
  task automatic idle(input int n);
    psel <= 1'h0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic summarize;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `PINS_7_8_SETUP_ADDR, 8'h0, 1'h1);
    chk("reset 0x21", rd, 32'h0);
    foreach (rows[i]) begin
      func_out <= rows[i][11:8];
      apb(1'h1, rows[i][20] ? `PINS_7_8_SETUP_ADDR : `PINS_5_6_SETUP_ADDR, rows[i][19:12], 1'h1);
      apb(1'h0, paddr, 8'h0, 1'h1);
      chk("readback", rd, {24'h0, rows[i][19:12]});
      idle(2);
      chk("pad_out", pad_out, rows[i][7:4]);
      chk("pad_oe_n", pad_oe_n, rows[i][3:0]);
    end
    apb(1'h1, 12'h088, 8'hff, 1'h1);
    chk("unmapped err", er, 1'h1);
    apb(1'h1, `PINS_5_6_SETUP_ADDR, 8'h55, 1'h0);
    apb(1'h0, `PINS_5_6_SETUP_ADDR, 8'h0, 1'h1);
    chk("masked write", rd, 32'h0);
    apb(1'h1, `PINS_5_6_SETUP_ADDR, 8'h03, 1'h1);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) apb(1'h1, `PINS_5_6_SETUP_ADDR, 8'h02, 1'h1);
      lvl <= {3'h0, k == 1};
      idle(6);
      chk("pin in", pin_in_level, {3'h0, k > 0});
    end
    presetn <= 1'h0;
    idle(2);
    presetn <= 1'h1;
    apb(1'h0, `PINS_5_6_SETUP_ADDR, 8'h0, 1'h1);
    chk("reset 0x20", rd, 32'h0);
    idle(1);
    chk("reset oe", pad_oe_n, 4'h0);
    summarize();
  end
endmodule
